// ---- rtl/strap_mode_select_loader.sv ----
// strap mode-select loader with ahb-lite register slave
// assumes strap level codes come from an asynchronous comparator bank
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module strap_mode_select_loader (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] strap_config_input_first_i,
  input wire logic [2:0] strap_config_input_second_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic remote_table_found_i,
  output logic strap_done_o,
  output logic display_id_source_select_o,
  output logic remote_search_en_o,
  output logic remote_display_id_copy_o,
  output logic [7:0] remote_id_addr_o,
  output logic aux_audio_en_o,
  output logic external_controller_override_o,
  output logic cable_medium_select_o,
  output logic use_internal_sram_o
);
  // four flops per strap bit; only the second stage reads the first
  logic [4:0] strap_raw;
  logic [4:0] sync2_w;
  logic [4:0] sync3_w;
  logic [4:0] stable_w;
  assign strap_raw = {strap_config_input_second_i, strap_config_input_first_i};

  genvar b;
  generate
    for (b = 0; b < $bits(strap_raw); b++)
    begin : g_sync
      logic sync1_r;
      logic sync2_r;
      logic sync3_r;
      logic stable_r;
      logic agree;
      assign agree = (sync2_r == sync3_r);
      always_ff @(posedge core_clk_i)
      begin
        if (!rst_n_i)
        begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          sync3_r <= 1'b0;
        end
        else
        begin
          sync1_r <= strap_raw[b];
          sync2_r <= sync1_r;
          sync3_r <= sync2_r;
        end
      end
      // a level counts only once the last two stages agree
      always_ff @(posedge core_clk_i)
      begin
        if (!rst_n_i)
          stable_r <= 1'b0;
        else if (agree)
          stable_r <= sync3_r;
      end
      assign sync2_w[b] = sync2_r;
      assign sync3_w[b] = sync3_r;
      assign stable_w[b] = stable_r;
    end
  endgenerate

  // loader sequence: settle, latch once, then hold until the next reset
  typedef enum logic [1:0] {
    loader_settle = 2'b00,
    loader_held = 2'b01
  } loader_state_t;
  loader_state_t state_r;
  loader_state_t state_nxt;
  logic [4:0] settle_r;
  logic [4:0] settle_nxt;
  logic straps_latched;
  logic strap_moving;
  logic settle_hit;
  logic capture;
  assign strap_moving = (sync2_w != sync3_w);
  assign settle_hit = (settle_r == strap_loader_pkg::SETTLE_LAST);
  assign straps_latched = (state_r == loader_held);
  assign capture = (state_r == loader_settle) && settle_hit; // RULE18

  // a moving divider restarts the wait so a half-settled level is not latched
  always_comb
  begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      loader_settle:
      begin
        if (capture)
          state_nxt = loader_held; // RULE1
        else if (strap_moving)
          settle_nxt = 5'h0_0;
        else
          settle_nxt = settle_r + 5'h0_1;
      end
      loader_held:
        state_nxt = loader_held; // RULE18
      default:
        state_nxt = loader_settle;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      state_r <= loader_settle;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      settle_r <= 5'h0_0;
    else
      settle_r <= settle_nxt;
  end

  // decoded strap fields: the level index is the binary setting
  logic st_sel, st_aux, st_ext, st_cable_medium_select, st_load;
  assign st_sel = stable_w[1]; // RULE10
  assign st_aux = stable_w[0]; // RULE10
  assign st_ext = stable_w[4]; // RULE11
  assign st_cable_medium_select = stable_w[3]; // RULE11
  assign st_load = stable_w[2]; // RULE11

  // ahb-lite address phase capture
  logic wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  logic take;
  assign take = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h0_0;
    end
    else if (hready_i)
    begin
      wr_pend_r <= take && hwrite_i;
      rd_pend_r <= take && !hwrite_i;
      // registers sit one per word: the byte address is four times the index
      addr_r <= haddr_i[9:2];
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  logic wr_ctl, wr_cfg, wr_dual, wr_addr;
  assign wr_ctl = wr_pend_r && (addr_r == strap_loader_pkg::BRIDGE_CONTROL_OFS);
  assign wr_cfg = wr_pend_r && (addr_r == strap_loader_pkg::BRIDGE_CONFIGURATION_OFS);
  assign wr_dual = wr_pend_r && (addr_r == strap_loader_pkg::DUAL_LINK_CONTROL_ONE_OFS);
  assign wr_addr = wr_pend_r && (addr_r == strap_loader_pkg::REMOTE_ID_ADDR_OFS);

  logic [7:0] bridge_control_r, bridge_configuration_r, dual_link_control_one_r;
  logic [7:0] remote_addr_r;
  logic [7:0] ctl_nxt, cfg_nxt, dual_nxt;

  // strap capture merged into the register images; a same-cycle write wins later
  always_comb
  begin
    ctl_nxt = bridge_control_r;
    cfg_nxt = bridge_configuration_r;
    dual_nxt = dual_link_control_one_r;
    if (capture)
    begin
      ctl_nxt[strap_loader_pkg::DISPLAY_ID_DISABLE_BIT] = st_sel; // RULE1 RULE12
      cfg_nxt[strap_loader_pkg::AUDIO_MODE_HI_BIT] = st_aux; // RULE13
      cfg_nxt[strap_loader_pkg::EXTERNAL_CONTROL_FLAG_BIT] = st_ext; // RULE14
      cfg_nxt[strap_loader_pkg::REMOTE_COPY_BIT] = st_load; // RULE16
      dual_nxt[strap_loader_pkg::CABLE_MODE_BIT] = st_cable_medium_select; // RULE15
    end
    if (wr_ctl)
      ctl_nxt = hwdata_i[7:0]; // RULE3 RULE17
    if (wr_cfg)
      cfg_nxt = hwdata_i[7:0]; // RULE17
    if (wr_dual)
      dual_nxt = hwdata_i[7:0]; // RULE17
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      bridge_control_r <= strap_loader_pkg::BRIDGE_CONTROL_RST;
    else
      bridge_control_r <= ctl_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      bridge_configuration_r <= strap_loader_pkg::BRIDGE_CONFIGURATION_RST;
    else
      bridge_configuration_r <= cfg_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      dual_link_control_one_r <= strap_loader_pkg::DUAL_LINK_CONTROL_ONE_RST;
    else
      dual_link_control_one_r <= dual_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      remote_addr_r <= strap_loader_pkg::REMOTE_ID_ADDR_RST; // RULE4
    else if (wr_addr)
      remote_addr_r <= hwdata_i[7:0]; // RULE4
  end

  // read mux; unmapped addresses read zero
  logic [7:0] rd_byte;
  assign rd_byte =
    (addr_r == strap_loader_pkg::BRIDGE_CONTROL_OFS) ? bridge_control_r :
    (addr_r == strap_loader_pkg::BRIDGE_CONFIGURATION_OFS) ? bridge_configuration_r :
    (addr_r == strap_loader_pkg::DUAL_LINK_CONTROL_ONE_OFS) ? dual_link_control_one_r :
    (addr_r == strap_loader_pkg::REMOTE_ID_ADDR_OFS) ? remote_addr_r :
    (addr_r == strap_loader_pkg::LOADER_STATUS_OFS) ? {7'h0_0, straps_latched} : 8'h0_0;
  assign hrdata_o = rd_pend_r ? {24'h00_0000, rd_byte} : 32'h0000_0000; // RULE17

  // functional outputs steered by the live register bits
  logic sel_bit;
  assign sel_bit = bridge_control_r[strap_loader_pkg::DISPLAY_ID_DISABLE_BIT];
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      strap_done_o <= 1'b0;
    else
      strap_done_o <= straps_latched;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      display_id_source_select_o <= 1'b0;
    else
      display_id_source_select_o <= sel_bit; // RULE5
  end

  // no remote search before the straps are known
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      remote_search_en_o <= 1'b0;
    else
      remote_search_en_o <= straps_latched && !sel_bit; // RULE2 RULE5
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      remote_display_id_copy_o <= 1'b0;
    else
      remote_display_id_copy_o <= straps_latched && !sel_bit && remote_table_found_i &&
        bridge_configuration_r[strap_loader_pkg::REMOTE_COPY_BIT]; // RULE9
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      remote_id_addr_o <= strap_loader_pkg::REMOTE_ID_ADDR_RST;
    else
      remote_id_addr_o <= remote_addr_r; // RULE4
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      aux_audio_en_o <= 1'b0;
    else
      aux_audio_en_o <= bridge_configuration_r[strap_loader_pkg::AUDIO_MODE_HI_BIT]; // RULE6
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      external_controller_override_o <= 1'b0;
    else
      external_controller_override_o <=
        bridge_configuration_r[strap_loader_pkg::EXTERNAL_CONTROL_FLAG_BIT]; // RULE7
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      cable_medium_select_o <= 1'b0;
    else
      cable_medium_select_o <= dual_link_control_one_r[strap_loader_pkg::CABLE_MODE_BIT]; // RULE8
  end

  // with select 0, sram table used when remote absent, or copy disabled
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      use_internal_sram_o <= 1'b0;
    else
      use_internal_sram_o <= !sel_bit && (!remote_table_found_i ||
        !bridge_configuration_r[strap_loader_pkg::REMOTE_COPY_BIT]); // RULE2 RULE9
  end
endmodule

// ---- rtl/strap_loader_pkg.sv ----
// constants for the strap-latched configuration loader
// assumes an analog front end delivers each strap as a level code
// How it works
// RULE1: straps are sampled at power-up into register bits; software may also write them
// RULE2: select 0 searches for a remote display-id table, else uses internal sram table
// RULE3: with select 0 a register write overrides the pin-chosen display-id behaviour
// RULE4: remote display-id address defaults to 0xa0 and software may replace it
// RULE5: select 1 uses the external local display-id source, no remote search
// RULE6: aux audio 0 carries link audio only; 1 adds the auxiliary channel
// RULE7: external control 0 means internal link control; 1 means two-wire external control
// RULE8: cable type 0 is twisted pair, 1 is coaxial
// RULE9: remote load 1 copies an available remote table into sram; 0 keeps sram
// RULE10: first strap decodes four levels to select and aux audio 00..11
// RULE11: second strap decodes eight levels to control, cable, load 000..111
// RULE12: display-id select lands in bridge control 0x4f bit 0
// RULE13: aux audio lands in bridge configuration 0x54 bit 1
// RULE14: external control lands in bridge configuration 0x54 bit 7
// RULE15: cable type lands in dual-link control 0x5b bit 7
// RULE16: remote load lands in bridge configuration 0x54 bit 5
// RULE17: software reads back and rewrites every strap bit, and the new value acts
// RULE18: straps are captured once after reset; later pin changes are ignored
package strap_loader_pkg;
  localparam logic [7:0] BRIDGE_CONTROL_OFS = 8'h4F;
  localparam logic [7:0] BRIDGE_CONFIGURATION_OFS = 8'h54;
  localparam logic [7:0] DUAL_LINK_CONTROL_ONE_OFS = 8'h5B;
  localparam logic [7:0] REMOTE_ID_ADDR_OFS = 8'h60;
  localparam logic [7:0] LOADER_STATUS_OFS = 8'h64;
  localparam int DISPLAY_ID_DISABLE_BIT = 0;
  localparam int AUDIO_MODE_HI_BIT = 1;
  localparam int REMOTE_COPY_BIT = 5;
  localparam int EXTERNAL_CONTROL_FLAG_BIT = 7;
  localparam int CABLE_MODE_BIT = 7;
  localparam logic [7:0] BRIDGE_CONTROL_RST = 8'h00;
  localparam logic [7:0] BRIDGE_CONFIGURATION_RST = 8'h00;
  localparam logic [7:0] DUAL_LINK_CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] REMOTE_ID_ADDR_RST = 8'hA0;
  localparam int SETTLE_CYCLES = 16;
  localparam logic [4:0] SETTLE_LAST = 5'h10;
endpackage

// ---- tb/strap_divider_model.sv ----
// resistor-divider straps on the two mode-select pins, as level indices
// assumes the bench picks the divider ratio index of each strap
`timescale 1ns/1ps
module strap_divider_model (
  input wire logic [1:0] ratio_first_i,
  input wire logic [2:0] ratio_second_i,
  output logic [1:0] strap_first_o,
  output logic [2:0] strap_second_o
);
  // a divider level follows its ratio index at once; analog settling is not modelled
  assign strap_first_o = ratio_first_i;
  assign strap_second_o = ratio_second_i;
endmodule

// ---- tb/strap_loader_monitor.sv ----
// checker for the strap loader: bus response, derived outputs, register writes
// assumes only the loader's own ports, attached by bind
`timescale 1ns/1ps
module strap_loader_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic strap_done_o,
  input wire logic display_id_source_select_o,
  input wire logic remote_search_en_o,
  input wire logic remote_display_id_copy_o,
  input wire logic [7:0] remote_id_addr_o,
  input wire logic aux_audio_en_o,
  input wire logic external_controller_override_o,
  input wire logic cable_medium_select_o,
  input wire logic use_internal_sram_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence addr_wr_s(logic [7:0] a);
    hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[9:2] == a;
  endsequence
  // output may sit one flop behind the register, hence the two-cycle window
  property wr_lands_p(logic [7:0] a, logic d, logic o);
    logic v;
    (addr_wr_s(a) ##1 (1'b1, v = d)) |-> ##[1:2] o == v;
  endproperty
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or error");
  a_addr_reset: assert property ($rose(rst_n_i) |-> remote_id_addr_o == 8'hA0) else $error("bad addr");
  a_done_holds: assert property (strap_done_o |=> strap_done_o) else $error("done dropped");
  a_search_sel: assert property (strap_done_o && $past(strap_done_o, 2)
    |-> ##[0:1] remote_search_en_o != display_id_source_select_o) else $error("search");
  a_copy_gate: assert property (remote_display_id_copy_o |-> remote_search_en_o) else $error("copy");
  a_sram_excl: assert property (!(use_internal_sram_o && remote_display_id_copy_o)) else $error("sram");
  a_sel_write: assert property (wr_lands_p(8'h4F, hwdata_i[0], display_id_source_select_o)) else $error("sel");
  a_aux_write: assert property (wr_lands_p(8'h54, hwdata_i[1], aux_audio_en_o)) else $error("aux");
  a_ext_write: assert property (wr_lands_p(8'h54, hwdata_i[7], external_controller_override_o)) else $error("ext");
  a_cable_write: assert property (wr_lands_p(8'h5B, hwdata_i[7], cable_medium_select_o)) else $error("cable");
endmodule
bind strap_mode_select_loader strap_loader_monitor mon (.*);

// ---- tb/tb_top.sv ----
// self-checking bench for the strap loader over every level of each strap, in eight level pairs
// assumes an ahb-lite slave with one register per word, byte address four times the index
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb_top;
  logic core_clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0;
  logic remote_table_found_i = 0, strap_done_o, display_id_source_select_o;
  logic [1:0] htrans_i = 0, lvl_f = 0, strap_config_input_first_i;
  logic [2:0] hsize_i = 3'h2, lvl_s = 0, strap_config_input_second_i;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, q, d, seed = 32'h38ad_e5f0;
  logic hreadyout_o, hresp_o, remote_search_en_o, remote_display_id_copy_o, aux_audio_en_o;
  logic external_controller_override_o, cable_medium_select_o, use_internal_sram_o;
  logic [7:0] remote_id_addr_o;
  wire hready_i = hreadyout_o;
  int n_tests = 0, miscompares = 0, cyc = 0;
  strap_divider_model div (.ratio_first_i(lvl_f), .ratio_second_i(lvl_s),
    .strap_first_o(strap_config_input_first_i), .strap_second_o(strap_config_input_second_i));
  strap_mode_select_loader uut (.*);
  always #4 core_clk_i = ~core_clk_i;
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
    hsel_i <= 1'h1;
    haddr_i <= {22'h00_0000, a, 2'h0};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'h1);
    htrans_i <= 2'h0;
    hsel_i <= 1'h0;
    hwdata_i <= dw;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'h1);
    q = hrdata_o;
  endtask
  // bridge control, bridge configuration, dual-link control one
  function automatic logic [23:0] regs_exp(input logic [1:0] f, input logic [2:0] s);
    return {7'h00, f[1], s[2], 1'h0, s[0], 3'h0, f[0], 1'h0, s[1], 7'h00};
  endfunction
  task automatic chk_regs(input logic [23:0] e);
    bus(0, 8'h4F, 0);
    `CHK(q, {24'h00_0000, e[23:16]})
    bus(0, 8'h54, 0);
    `CHK(q, {24'h00_0000, e[15:8]})
    bus(0, 8'h5B, 0);
    `CHK(q, {24'h00_0000, e[7:0]})
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk_i);
      rst_n_i <= 1'h0;
      lvl_f <= i[1:0];
      lvl_s <= i[2:0];
      remote_table_found_i <= 1'($random(seed));
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      repeat (40) @(posedge core_clk_i);
      `CHK(strap_done_o, 1'h1)
      chk_regs(regs_exp(lvl_f, lvl_s));
      `CHK(remote_id_addr_o, 8'hA0)
      `CHK({display_id_source_select_o, aux_audio_en_o}, lvl_f)
      `CHK({external_controller_override_o, cable_medium_select_o}, lvl_s[2:1])
      `CHK(remote_display_id_copy_o, !lvl_f[1] && remote_table_found_i && lvl_s[0])
      `CHK(use_internal_sram_o, !lvl_f[1] && !(remote_table_found_i && lvl_s[0]))
      lvl_f <= ~lvl_f;
      lvl_s <= ~lvl_s;
      repeat (40) @(posedge core_clk_i);
      chk_regs(regs_exp(~lvl_f, ~lvl_s));
      $display("strap pair %0d done", i);
    end
    d = $random(seed);
    bus(1, 8'h4F, d);
    bus(1, 8'h54, ~d);
    bus(1, 8'h5B, d);
    bus(1, 8'h60, d);
    bus(0, 8'h54, 0);
    `CHK(q, {24'h00_0000, ~d[7:0]})
    bus(0, 8'h70, 0);
    `CHK(q, 32'h0000_0000)
    `CHK(display_id_source_select_o, d[0])
    `CHK({external_controller_override_o, aux_audio_en_o}, ~{d[7], d[1]})
    `CHK(cable_medium_select_o, d[7])
    `CHK(remote_id_addr_o, d[7:0])
    $display("register rewrite done");
    end_of_test();
  end
endmodule
